/* File: rtl/block_block_transfer_op_consts.vh */
// Constants for the block word transfer unit: map, fields, codes and timing.
`ifndef BLOCK_BLOCK_TRANSFER_OP_CONSTS_VH
`define BLOCK_BLOCK_TRANSFER_OP_CONSTS_VH

`define CLK_KHZ         25000
`define TICK_MS         1
`define MS_CYCLES       16'h61A8

`define REG_CTRL        8'h00
`define REG_STAT        8'h04
`define REG_SRC_TYPE    8'h08
`define REG_SRC_ADDR    8'h0C
`define REG_SIZE        8'h10
`define REG_RX_STAT     8'h14
`define REG_RX_LEN      8'h18
`define REG_DST_TYPE    8'h1C
`define REG_DST_ADDR    8'h20
`define REG_PORT_CFG    8'h24
`define RAM_WIN_BIT     15

`define CTRL_EN         0
`define CTRL_GO         1
`define CTRL_SUB1       2
`define STAT_BUSY       0
`define STAT_OUT        1
`define STAT_ERR        2
`define STAT_LOCK       3
`define CFG_MODE_LSB    0
`define CFG_BAUD_LSB    4

`define TYPE_RW         16'h0003
`define TYPE_D          16'h0004
`define TYPE_EE         16'h0020
`define TYPE_SER        16'h0030
`define RW_WORDS        17'h00100
`define D_WORDS         17'h01000
`define EE_WORDS        17'h00800
`define RW_RAM_BASE     13'h1000
`define RAM_AW          13
`define MAX_SIZE        16'h0100
`define SER_SIZE        16'h0100
`define EE_PAGE         17'h00020
`define MAX_MSG         10'h200

`define RX_OK           16'h0000
`define RX_COMM         16'h0001
`define RX_LONG         16'h0002
`define RX_OVF          16'h0003
`define RX_TMO          16'h0004

`define MODE_FREE_ASCII 2'h1
`define BAUD_2400       3'h3
`define BAUD_4800       3'h4
`define BAUD_9600       3'h5
`define BAUD_19200      3'h6

`define LOCK_MS         4'hA
`define TMO_LOW_MS      15'h7530
`define TMO_2400_MS     15'h3A98
`define TMO_4800_MS     15'h1B58
`define TMO_9600_MS     15'h0BB8
`define TMO_19200_MS    15'h05DC

`define RST_WORD        16'h0000
`define RST_MODE        2'h0
`define RST_BAUD        3'h0

`endif

/* File: rtl/ram_word_mem.v */
// Single-port word memory holding the data and work register files.
`include "block_block_transfer_op_consts.vh"

module ram_word_mem (
  input  wire                clk_i,
  input  wire                en_i,
  input  wire                we_i,
  input  wire [`RAM_AW-1:0]  addr_i,
  input  wire [15:0]         wdata_i,
  output reg  [15:0]         rdata_o
);

  reg [15:0] mem_q [0:(1<<`RAM_AW)-1];

  // Read data is registered and holds until the next enabled read.
  always @(posedge clk_i) begin
    if (en_i) begin
      if (we_i) begin
        mem_q[addr_i] <= wdata_i;
      end else begin
        rdata_o <= mem_q[addr_i];
      end
    end
  end

endmodule

/* File: rtl/block_word_transfer_unit.v */
// Block word transfer engine between word RAM, EEPROM and serial receive buffer.
`include "block_block_transfer_op_consts.vh"

// Notes on behaviour
// (RL1) Source, destination as type plus address; size word.
// (RL2) Sizes 1 to 256 words accepted.
// (RL3) Only RAM with EEPROM or serial allowed.
// (RL4) Type 0004 is RAM, addresses to 4095.
// (RL5) Type 0020 EEPROM to 2047; 0030 serial, zero.
// (RL6) EEPROM write at most 32 words.
// (RL7) EEPROM write must not cross page boundary.
// (RL8) EEPROM reads ignore pages.
// (RL9) EEPROM locked 10 ms after every write.
// (RL10) Wear alarm flag never touched here.
// (RL11) Bad size, range or pairing: skip, flag.
// (RL12) Error flag sticky until software clears.
// (RL13) Output on when enabled, even on error.
// (RL14) Program serialises issuers; busy requests ignored.
// (RL15) Receive one message into RAM, size 256.
// (RL16) Receive writes status and byte length.
// (RL17) Enable must stay on through a receive.
// (RL18) Five receive status codes.
// (RL19) Length zero when nothing, else 1..512.
// (RL20) Receive timeout depends on baud rate.
// (RL21) Serial refused: address, size, mode, subprogram.
module block_word_transfer_unit #(
  parameter [15:0] MS_CYCLES = `MS_CYCLES
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [15:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire        wb_ack_o,
  output wire [10:0] ee_addr_o,
  output wire [15:0] ee_wdata_o,
  output wire        ee_we_o,
  output wire        ee_re_o,
  input  wire [15:0] ee_rdata_i,
  input  wire        rx_valid_i,
  input  wire [7:0]  rx_byte_i,
  input  wire        rx_end_i,
  input  wire        rx_err_i,
  input  wire        rx_ovf_i,
  output wire        rx_pop_o,
  output wire        instr_out_o,
  output wire        instr_error_flag_o
);

  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_WAIT = 5'b00010;
  localparam [4:0] S_COPY = 5'b00100;
  localparam [4:0] S_RX   = 5'b01000;
  localparam [4:0] S_DONE = 5'b10000;
  localparam [15:0] TICK_LAST = MS_CYCLES - 16'h0001;

  reg  [4:0]  state_q;
  reg  [15:0] src_type_q;
  reg  [15:0] src_addr_q;
  reg  [15:0] size_q;
  reg  [15:0] dst_type_q;
  reg  [15:0] dst_addr_q;
  reg  [15:0] rx_stat_q;
  reg  [15:0] rx_len_q;
  reg         en_q;
  reg         go_q;
  reg         sub1_q;
  reg  [1:0]  mode_q;
  reg  [2:0]  baud_q;
  reg         err_q;
  reg         out_q;
  reg         ack_q;
  reg         pend_q;
  reg  [31:0] dat_q;
  reg  [31:0] rd_mux;
  reg  [10:0] ee_addr_q;
  reg  [15:0] ee_wdata_q;
  reg         ee_we_q;
  reg         ee_re_q;
  reg         rx_pop_q;
  reg  [15:0] tick_q;
  reg  [3:0]  lock_q;
  reg  [7:0]  idx_q;
  reg  [7:0]  last_q;
  reg  [1:0]  ph_q;
  reg         dir_q;
  reg  [12:0] ram_base_q;
  reg  [10:0] ee_base_q;
  reg  [9:0]  cnt_q;
  reg  [15:0] code_q;
  reg         first_q;
  reg  [7:0]  lo_q;
  reg  [14:0] tmo_q;
  reg  [14:0] tmo_lim;
  reg  [15:0] code_nx;
  reg         mem_en;
  reg         mem_we;
  reg  [12:0] mem_addr;
  reg  [15:0] mem_wd;
  wire [15:0] mem_rdata;

  wire [1:0]  is_ram;
  wire [1:0]  is_ee;
  wire [1:0]  is_ser;
  wire [1:0]  rng_ok;
  wire [12:0] ram_ix [0:1];

  // Bus side decode.
  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_q & ~pend_q;
  wire ram_sel = wb_adr_i[`RAM_WIN_BIT];
  wire hi_zero = (wb_adr_i[14:8] == 7'h00);
  wire [7:0] off = wb_adr_i[7:0];
  wire wr_ok = bus_req & ~ram_sel & hi_zero & wb_we_i & (wb_sel_i[1:0] == 2'b11);
  wire ram_go = bus_req & ram_sel & (state_q == S_IDLE);
  wire wr_ctrl = wr_ok & (off == `REG_CTRL);
  wire wr_stat = wr_ok & (off == `REG_STAT);

  wire tick = (tick_q == TICK_LAST);
  wire lock_on = (lock_q != 4'h0);
  wire busy = (state_q != S_IDLE);

  // Both operands are decoded alike: a type word names the table, the next word its start.
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : side
      wire [15:0] t = (g == 0) ? src_type_q : dst_type_q; // RL1
      wire [15:0] a = (g == 0) ? src_addr_q : dst_addr_q;
      wire [16:0] s = {1'b0, a} + {1'b0, size_q};
      wire rw = (t == `TYPE_RW);
      wire dr = (t == `TYPE_D); // RL4
      assign is_ram[g] = rw | dr;
      assign is_ee[g] = (t == `TYPE_EE); // RL5
      assign is_ser[g] = (t == `TYPE_SER); // RL5
      assign rng_ok[g] = rw ? (s <= `RW_WORDS) :
                         dr ? (s <= `D_WORDS) :
                         is_ee[g] ? (s <= `EE_WORDS) :
                         is_ser[g] ? (a == 16'h0000) : 1'b0; // RL21
      assign ram_ix[g] = rw ? (`RW_RAM_BASE + {5'h00, a[7:0]}) : a[12:0];
    end
  endgenerate

  wire size_ok = (size_q != 16'h0000) & (size_q <= `MAX_SIZE); // RL2
  wire [16:0] page_end = {12'h000, dst_addr_q[4:0]} + {1'b0, size_q};
  wire ee_ok = ~is_ee[1] | (page_end <= `EE_PAGE); // RL6 RL7
  wire ser_ok = ~is_ser[0] | ((size_q == `SER_SIZE) & (mode_q == `MODE_FREE_ASCII) & ~sub1_q); // RL21
  wire pair_ok = (is_ram[0] & is_ee[1]) | (is_ee[0] & is_ram[1]) | (is_ser[0] & is_ram[1]); // RL3
  wire bad = ~(pair_ok & rng_ok[0] & rng_ok[1] & size_ok & ee_ok & ser_ok); // RL11

  // A start that lands while an operation runs is dropped, so issuers must not overlap.
  wire start = go_q & en_q & ~busy; // RL13 RL14
  wire set_err = start & bad; // RL11
  wire lock_load = (state_q == S_COPY) & (ph_q == 2'h2) & dir_q & (idx_q == last_q); // RL9

  wire rx_take = (state_q == S_RX) & en_q & rx_valid_i & ~rx_pop_q;
  wire rx_store = rx_take & (cnt_q != `MAX_MSG);
  wire [9:0] cnt_nx = rx_store ? (cnt_q + 10'h001) : cnt_q;
  wire [12:0] ram_now = ram_base_q + {5'h00, idx_q};
  wire [12:0] ram_rx = ram_base_q + {4'h0, cnt_q[9:1]};
  wire [10:0] ee_now = ee_base_q + {3'h0, idx_q};
  wire tmo_hit = (tmo_q >= tmo_lim);

  always @* begin
    case (baud_q)
      `BAUD_2400:  tmo_lim = `TMO_2400_MS; // RL20
      `BAUD_4800:  tmo_lim = `TMO_4800_MS;
      `BAUD_9600:  tmo_lim = `TMO_9600_MS;
      `BAUD_19200: tmo_lim = `TMO_19200_MS;
      default:     tmo_lim = `TMO_LOW_MS;
    endcase
  end

  // The first fault seen in a message decides its status.
  always @* begin
    if (code_q != `RX_OK) begin
      code_nx = code_q;
    end else if (rx_err_i) begin
      code_nx = `RX_COMM; // RL18
    end else if (rx_ovf_i) begin
      code_nx = `RX_OVF;
    end else if (cnt_q == `MAX_MSG) begin
      code_nx = `RX_LONG;
    end else begin
      code_nx = `RX_OK;
    end
  end

  // The engine owns the memory while busy; bus accesses to RAM wait for idle.
  always @* begin
    mem_en = 1'b0;
    mem_we = 1'b0;
    mem_addr = 13'h0000;
    mem_wd = 16'h0000;
    if (state_q == S_COPY) begin
      mem_addr = ram_now;
      if (dir_q) begin
        mem_en = (ph_q == 2'h0);
      end else begin
        mem_en = (ph_q == 2'h2);
        mem_we = (ph_q == 2'h2);
        mem_wd = ee_rdata_i;
      end
    end else if (rx_store) begin
      mem_en = 1'b1;
      mem_we = 1'b1;
      mem_addr = ram_rx;
      mem_wd = cnt_q[0] ? {rx_byte_i, lo_q} : {8'h00, rx_byte_i}; // RL15
    end else if (ram_go) begin
      mem_en = 1'b1;
      mem_we = wb_we_i & (wb_sel_i[1:0] == 2'b11);
      mem_addr = wb_adr_i[14:2];
      mem_wd = wb_dat_i[15:0];
    end
  end

  ram_word_mem u_mem (
    .clk_i   (clk_i),
    .en_i    (mem_en),
    .we_i    (mem_we),
    .addr_i  (mem_addr),
    .wdata_i (mem_wd),
    .rdata_o (mem_rdata)
  );

  always @* begin
    rd_mux = 32'h00000000;
    if (hi_zero) begin
      case (off)
        `REG_CTRL:     rd_mux = {29'h0, sub1_q, 1'b0, en_q};
        `REG_STAT:     rd_mux = {28'h0, lock_on, err_q, out_q, busy};
        `REG_SRC_TYPE: rd_mux = {16'h0, src_type_q};
        `REG_SRC_ADDR: rd_mux = {16'h0, src_addr_q};
        `REG_SIZE:     rd_mux = {16'h0, size_q};
        `REG_RX_STAT:  rd_mux = {16'h0, rx_stat_q};
        `REG_RX_LEN:   rd_mux = {16'h0, rx_len_q};
        `REG_DST_TYPE: rd_mux = {16'h0, dst_type_q};
        `REG_DST_ADDR: rd_mux = {16'h0, dst_addr_q};
        `REG_PORT_CFG: rd_mux = {25'h0, baud_q, 2'h0, mode_q};
        default:       rd_mux = 32'h00000000;
      endcase
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      pend_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= 1'b0;
      pend_q <= 1'b0;
      if (pend_q) begin
        ack_q <= 1'b1;
        dat_q <= {16'h0000, mem_rdata};
      end else if (bus_req & ~ram_sel) begin
        ack_q <= 1'b1;
        dat_q <= rd_mux;
      end else if (ram_go) begin
        ack_q <= wb_we_i;
        pend_q <= ~wb_we_i;
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= 1'b0;
      go_q <= 1'b0;
      sub1_q <= 1'b0;
      src_type_q <= `RST_WORD;
      src_addr_q <= `RST_WORD;
      size_q <= `RST_WORD;
      dst_type_q <= `RST_WORD;
      dst_addr_q <= `RST_WORD;
      mode_q <= `RST_MODE;
      baud_q <= `RST_BAUD;
      err_q <= 1'b0;
    end else begin
      go_q <= wr_ctrl & wb_dat_i[`CTRL_GO];
      if (wr_ctrl) begin
        en_q <= wb_dat_i[`CTRL_EN];
        sub1_q <= wb_dat_i[`CTRL_SUB1];
      end
      if (wr_ok & (off == `REG_SRC_TYPE)) src_type_q <= wb_dat_i[15:0];
      if (wr_ok & (off == `REG_SRC_ADDR)) src_addr_q <= wb_dat_i[15:0];
      if (wr_ok & (off == `REG_SIZE)) size_q <= wb_dat_i[15:0];
      if (wr_ok & (off == `REG_DST_TYPE)) dst_type_q <= wb_dat_i[15:0];
      if (wr_ok & (off == `REG_DST_ADDR)) dst_addr_q <= wb_dat_i[15:0];
      if (wr_ok & (off == `REG_PORT_CFG)) begin
        mode_q <= wb_dat_i[`CFG_MODE_LSB+1:`CFG_MODE_LSB];
        baud_q <= wb_dat_i[`CFG_BAUD_LSB+2:`CFG_BAUD_LSB];
      end
      // Only a write of one clears; a new error in the same cycle wins.
      err_q <= set_err | (err_q & ~(wr_stat & wb_dat_i[`STAT_ERR])); // RL12
    end
  end

  // Millisecond tick, restarted on lock so the lockout never runs short.
  always @(posedge clk_i) begin
    if (rst_i | lock_load | tick) begin
      tick_q <= 16'h0000;
    end else begin
      tick_q <= tick_q + 16'h0001;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      lock_q <= 4'h0;
    end else if (lock_load) begin
      lock_q <= `LOCK_MS; // RL9
    end else if (tick & lock_on) begin
      lock_q <= lock_q - 4'h1;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= S_IDLE;
      ee_addr_q <= 11'h000;
      ee_wdata_q <= 16'h0000;
      ee_we_q <= 1'b0;
      ee_re_q <= 1'b0;
      rx_pop_q <= 1'b0;
      out_q <= 1'b0;
      rx_stat_q <= `RX_OK;
      rx_len_q <= 16'h0000;
      idx_q <= 8'h00;
      last_q <= 8'h00;
      ph_q <= 2'h0;
      dir_q <= 1'b0;
      ram_base_q <= 13'h0000;
      ee_base_q <= 11'h000;
      cnt_q <= 10'h000;
      code_q <= `RX_OK;
      first_q <= 1'b0;
      lo_q <= 8'h00;
      tmo_q <= 15'h0000;
    end else begin
      ee_re_q <= 1'b0;
      ee_we_q <= 1'b0;
      rx_pop_q <= rx_take;
      if (!en_q) out_q <= 1'b0; // RL13
      case (state_q)
        S_IDLE: begin
          if (start) begin
            idx_q <= 8'h00;
            ph_q <= 2'h0;
            last_q <= size_q[7:0] - 8'h01;
            dir_q <= is_ram[0];
            ram_base_q <= is_ram[0] ? ram_ix[0] : ram_ix[1];
            ee_base_q <= is_ee[0] ? src_addr_q[10:0] : dst_addr_q[10:0];
            cnt_q <= 10'h000;
            code_q <= `RX_OK;
            first_q <= 1'b1;
            tmo_q <= 15'h0000;
            if (bad) begin
              state_q <= S_DONE; // RL11
            end else if (is_ser[0]) begin
              state_q <= S_RX;
            end else if (lock_on) begin
              state_q <= S_WAIT; // RL9
            end else begin
              state_q <= S_COPY;
            end
          end
        end
        S_WAIT: begin
          if (!lock_on) state_q <= S_COPY;
        end
        S_COPY: begin
          // Three cycles per word: fetch, present, commit. Reads run straight across pages.
          case (ph_q)
            2'h0: begin
              ph_q <= 2'h1;
              if (!dir_q) begin
                ee_re_q <= 1'b1; // RL8
                ee_addr_q <= ee_now;
              end
            end
            2'h1: begin
              ph_q <= 2'h2;
              if (dir_q) begin
                // The wear alarm flag lives elsewhere and is left alone by these writes.
                ee_we_q <= 1'b1; // RL10
                ee_addr_q <= ee_now;
                ee_wdata_q <= mem_rdata;
              end
            end
            default: begin
              ph_q <= 2'h0;
              idx_q <= idx_q + 8'h01;
              if (idx_q == last_q) state_q <= S_DONE;
            end
          endcase
        end
        S_RX: begin
          if (!en_q) begin
            state_q <= S_IDLE; // RL17
          end else if (first_q & ~rx_valid_i) begin
            rx_stat_q <= `RX_OK; // RL19
            rx_len_q <= 16'h0000;
            state_q <= S_DONE;
          end else if (tmo_hit) begin
            rx_stat_q <= `RX_TMO; // RL18 RL20
            rx_len_q <= {6'h00, cnt_q};
            state_q <= S_DONE;
          end else begin
            if (tick & ~first_q) tmo_q <= tmo_q + 15'h0001;
            if (rx_take) begin
              first_q <= 1'b0;
              code_q <= code_nx;
              cnt_q <= cnt_nx;
              if (!cnt_q[0]) lo_q <= rx_byte_i;
              if (rx_end_i) begin
                rx_stat_q <= code_nx; // RL16
                rx_len_q <= {6'h00, cnt_nx}; // RL19
                state_q <= S_DONE;
              end
            end
          end
        end
        S_DONE: begin
          out_q <= en_q; // RL13
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;
  assign ee_addr_o = ee_addr_q;
  assign ee_wdata_o = ee_wdata_q;
  assign ee_we_o = ee_we_q;
  assign ee_re_o = ee_re_q;
  assign rx_pop_o = rx_pop_q;
  assign instr_out_o = out_q;
  assign instr_error_flag_o = err_q;

endmodule

/* File: tb/block_transfer_op_checker_assertions.sv */
// Port-level checker for the block word transfer unit.
module block_transfer_op_checker #(
  parameter [15:0] MS_CYCLES = 16'h61A8
) (
  input wire        clk_i,
  input wire        rst_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [15:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire        wb_ack_o,
  input wire        ee_we_o,
  input wire        ee_re_o,
  input wire        rx_valid_i,
  input wire        rx_pop_o,
  input wire        instr_out_o,
  input wire        instr_error_flag_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LOCK_M1 = 10 * MS_CYCLES - 1;
  logic [15:0] gap_q;
  logic        seen_q;
  wire         stat_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 16'h0004;
  wire         ctrl_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 16'h0000;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Words of one write operation are three cycles apart; any other gap must cover the lockout.
  always @(posedge clk_i) begin
    if (rst_i) begin
      gap_q  <= 16'h0000;
      seen_q <= 1'b0;
    end else if (ee_we_o) begin
      gap_q  <= 16'h0001;
      seen_q <= 1'b1;
    end else if (gap_q != 16'hFFFF) begin
      gap_q <= gap_q + 16'h0001;
    end
  end
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  a_lock_gap: assert property ((ee_we_o || ee_re_o) && seen_q |-> gap_q == 16'h0003 || gap_q >= LOCK_M1)
    else $error("eeprom accessed during lockout");
  a_pop_spacing: assert property (rx_pop_o |=> !rx_pop_o) else $error("pops back to back");
  a_pop_valid: assert property (rx_pop_o |-> $past(rx_valid_i)) else $error("pop of empty buffer");
  a_err_sticky: assert property (instr_error_flag_o && !stat_wr |=> instr_error_flag_o)
    else $error("error flag dropped by itself");
  a_out_hold: assert property (instr_out_o && !ctrl_wr |=> instr_out_o) else $error("output dropped");
  a_err_output: assert property ($rose(instr_error_flag_o) |=> instr_out_o)
    else $error("no output after error");
  a_skip_on_err: assert property ($rose(instr_error_flag_o) |-> (!ee_we_o && !rx_pop_o) [*8])
    else $error("transfer ran after error");
  a_engine_single: assert property (!(rx_pop_o && (ee_we_o || ee_re_o))) else $error("two paths at once");
  c_ee_burst: cover property (ee_we_o ##3 ee_we_o);
  c_err_rise: cover property ($rose(instr_error_flag_o));
  c_rx_pop: cover property (rx_pop_o);
endmodule

/* File: tb/block_transfer_op_partner.sv */
// Behavioural EEPROM array and serial receive buffer facing the transfer unit.
module block_transfer_op_partner (
  input  wire         clk_i,
  input  wire  [10:0] ee_addr_i,
  input  wire  [15:0] ee_wdata_i,
  input  wire         ee_we_i,
  input  wire         ee_re_i,
  output logic [15:0] ee_rdata_o,
  output wire         rx_valid_o,
  output wire  [7:0]  rx_byte_o,
  output wire         rx_end_o,
  output wire         rx_err_o,
  output wire         rx_ovf_o,
  input  wire         rx_pop_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:2047];
  logic [10:0] buf_m [0:1023];
  logic [7:0]  pat_q;
  int          hd;
  int          tl;
  initial begin
    hd = 0;
    tl = 0;
    pat_q = 8'h5A;
    ee_rdata_o = 16'h0000;
    for (int k = 0; k < 2048; k++) mem[k] = 16'(k * 7 + 3);
  end
  // Read data is good for one cycle only; it then turns over so a late sample cannot pass.
  always @(posedge clk_i) begin
    pat_q <= ~pat_q + 8'h01;
    if (ee_we_i) mem[ee_addr_i] <= ee_wdata_i;
    ee_rdata_o <= ee_re_i ? mem[ee_addr_i] : ~ee_rdata_o;
    if (rx_pop_i && hd != tl) hd <= hd + 1;
  end
  assign rx_valid_o = hd != tl;
  assign {rx_err_o, rx_ovf_o, rx_end_o, rx_byte_o} = (hd != tl) ? buf_m[hd % 1024] : {3'b000, pat_q};
endmodule

/* File: tb/block_word_transfer_unit_bench.sv */
// Self-checking bench for the block word transfer unit.
`define CHK(nm, ex, sn) begin tests_run++; if ((sn) !== (ex)) begin err_count++; \
  $display("Error %s expected %h seen %h", nm, ex, sn); end end
module block_word_transfer_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_i, cyc, stb, we;
  logic [15:0] adr, s;
  logic [3:0]  sel;
  logic [31:0] dat, rd;
  wire  [31:0] dat_o;
  wire         ack, ee_we, ee_re, rx_valid, rx_end, rx_err, rx_ovf, rx_pop, iout, ierr;
  wire  [10:0] ee_addr;
  wire  [15:0] ee_wd, ee_rd;
  wire  [7:0]  rx_byte;
  int          err_count, tests_run, cyc_n, seed, i, j, n, m, t0, lim;
  logic [15:0] ram_m [0:4095];
  logic [7:0]  msg [0:599];
  logic [111:0] et [0:11], r;
  int          sn [0:6] = '{7, 0, 5, 5, 514, 1, 1};
  logic [15:0] sx [0:6] = '{16'h0000, 16'h0000, 16'h0001, 16'h0003, 16'h0002, 16'h0004, 16'h0004};
  block_word_transfer_unit #(.MS_CYCLES(16'h0004)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .ee_addr_o(ee_addr), .ee_wdata_o(ee_wd), .ee_we_o(ee_we), .ee_re_o(ee_re),
    .ee_rdata_i(ee_rd), .rx_valid_i(rx_valid), .rx_byte_i(rx_byte), .rx_end_i(rx_end), .rx_err_i(rx_err),
    .rx_ovf_i(rx_ovf), .rx_pop_o(rx_pop), .instr_out_o(iout), .instr_error_flag_o(ierr));
  block_transfer_op_partner P (.clk_i(clk_i), .ee_addr_i(ee_addr), .ee_wdata_i(ee_wd), .ee_we_i(ee_we), .ee_re_i(ee_re),
    .ee_rdata_o(ee_rd), .rx_valid_o(rx_valid), .rx_byte_o(rx_byte), .rx_end_o(rx_end), .rx_err_o(rx_err),
    .rx_ovf_o(rx_ovf), .rx_pop_i(rx_pop));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task final_report;
    $display("Checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n >= 90000) begin
      err_count++;
      final_report;
    end
  end
  task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] b);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= b;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 2000);
    if (k >= 2000) err_count++;
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task wr(input logic [15:0] a, input logic [15:0] d);
    wb(1'b1, a, {16'h0000, d}, 4'hF);
  endtask
  task rdw(input logic [15:0] a);
    wb(1'b0, a, 32'h00000000, 4'hF);
  endtask
  // Enable is held on while the status is polled, so a receive is never cut short.
  task automatic run(input logic [15:0] st, sa, sz, dt, da, cf, ct);
    int k;
    wr(16'h0000, 16'h0000);
    wr(16'h0008, st);
    wr(16'h000C, sa);
    wr(16'h0010, sz);
    wr(16'h001C, dt);
    wr(16'h0020, da);
    wr(16'h0024, cf);
    wr(16'h0000, ct | 16'h0003);
    repeat (3) @(posedge clk_i);
    k = 0;
    // The next operation is only started once busy has dropped.
    do begin
      rdw(16'h0004);
      k++;
    end while (rd[0] !== 1'b0 && k < 6000);
    if (k >= 6000) err_count++;
    s = rd[15:0];
  endtask
  function automatic logic [15:0] pk(int w, int c);
    return {(2 * w + 1 < c) ? msg[2 * w + 1] : 8'h00, msg[2 * w]};
  endfunction
  initial begin
    {cyc, stb, we, adr, sel, dat} = '0;
    {err_count, tests_run, cyc_n} = '0;
    seed = 50;
    rst_i = 1'b1;
    et = '{112'h0004_0000_0000_0020_0000_0000_0000, 112'h0020_0000_0101_0004_0000_0000_0000,
      112'h0004_0000_0021_0020_0000_0000_0000, 112'h0004_0000_0004_0020_001E_0000_0000,
      112'h0020_07F8_000A_0004_0000_0000_0000, 112'h0004_0FFA_000A_0020_0000_0000_0000,
      112'h0003_0000_0005_0004_0000_0000_0000, 112'h0004_0000_0100_0030_0000_0061_0000,
      112'h0030_0001_0100_0004_0000_0061_0000, 112'h0030_0000_00FF_0004_0000_0061_0000,
      112'h0030_0000_0100_0004_0000_0060_0000, 112'h0030_0000_0100_0004_0000_0061_0004};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rdw(16'h0004);
    `CHK("stat", 16'h0000, rd[15:0])
    rdw(16'h0040);
    `CHK("unmapped", 32'h00000000, rd)
    wb(1'b1, 16'h0010, 32'h0000ABCD, 4'hC);
    rdw(16'h0010);
    `CHK("size_sel", 16'h0000, rd[15:0])
    wr(16'h0000, 16'h0002);
    rdw(16'h0004);
    `CHK("no_enable", 16'h0000, rd[15:0])
    for (i = 700; i < 764; i++) begin
      ram_m[i] = 16'($random(seed));
      wr(16'(32'h8000 + 4 * i), ram_m[i]);
    end
    run(16'h0004, 16'h02BC, 16'h0020, 16'h0020, 16'h0020, 16'h0000, 16'h0000);
    `CHK("wr_stat", 2'b01, s[2:1])
    for (i = 0; i < 32; i++) `CHK("ee_page", ram_m[700 + i], P.mem[32 + i])
    n = 1 + ($unsigned($random(seed)) % 16);
    run(16'h0004, 16'h02DC, 16'(n), 16'h0020, 16'h0050, 16'h0000, 16'h0000);
    for (i = 0; i < n; i++) `CHK("ee_rand", ram_m[732 + i], P.mem[80 + i])
    run(16'h0020, 16'h0028, 16'h0030, 16'h0004, 16'h07D0, 16'h0000, 16'h0000);
    for (i = 0; i < 48; i++) begin
      rdw(16'(32'h8000 + 4 * (2000 + i)));
      `CHK("ee_read", P.mem[40 + i], rd[15:0])
    end
    for (i = 0; i < 12; i++) begin
      r = et[i];
      run(r[111:96], r[95:80], r[79:64], r[63:48], r[47:32], r[31:16], r[15:0]);
      `CHK("bad_err", 1'b1, s[2])
      `CHK("bad_out", 1'b1, s[1])
      `CHK("err_pin", 1'b1, ierr)
      `CHK("out_pin", 1'b1, iout)
      if (i < 11) wr(16'h0004, 16'h0004);
    end
    run(16'h0020, 16'h0000, 16'h0001, 16'h0004, 16'h0000, 16'h0000, 16'h0000);
    `CHK("sticky", 1'b1, s[2])
    wr(16'h0004, 16'h0004);
    rdw(16'h0004);
    `CHK("cleared", 1'b0, rd[2])
    for (i = 0; i < 7; i++) begin
      P.hd = P.tl;
      n = sn[i];
      for (j = 0; j < n; j++) begin
        msg[j] = 8'($random(seed));
        P.buf_m[P.tl % 1024] = {i == 2 && j == 1, i == 3 && j == 1, j == n - 1 && i < 5, msg[j]};
        P.tl++;
      end
      // The bench runs 4 cycles per millisecond: 1.5 s at 19200, 3 s at 9600.
      t0 = cyc_n;
      lim = (i == 6) ? 12000 : 6000;
      run(16'h0030, 16'h0000, 16'h0100, 16'h0004, 16'h0064, (i == 6) ? 16'h0051 : 16'h0061, 16'h0000);
      if (i > 4) `CHK("rx_tmo_time", 1'b1, cyc_n - t0 >= lim && cyc_n - t0 < lim + 200)
      m = (n > 512) ? 512 : n;
      `CHK("rx_out", 1'b1, s[1])
      rdw(16'h0014);
      `CHK("rx_status", sx[i], rd[15:0])
      rdw(16'h0018);
      `CHK("rx_len", 16'(m), rd[15:0])
      for (j = 0; j < (m + 1) / 2 && (i < 2 || i == 4); j++) begin
        rdw(16'(32'h8000 + 4 * (100 + j)));
        `CHK("rx_word", pk(j, m), rd[15:0])
      end
    end
    final_report;
  end
endmodule
bind block_word_transfer_unit block_transfer_op_checker #(.MS_CYCLES(MS_CYCLES)) chk (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o, .ee_we_o, .ee_re_o, .rx_valid_i, .rx_pop_o,
  .instr_out_o, .instr_error_flag_o);
